// File: logic/tlp_pkg.sv
// Purpose: Shared constants for the two-level interrupt priority unit.
// Assumes: APB register access, one word per register, 250 MHz clock.
// Notes: Register indices are word indices; byte address is index * 4.

package tlp_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CORE = 5;
   localparam int NUM_PREG = 5;
   localparam int NUM_PERIPH = 8 * NUM_PREG;
   localparam int NUM_SRC = NUM_CORE + NUM_PERIPH;
   localparam int REG_COUNT = 19;

   // ----------------------------------------------------------------
   // Register word indices
   // ----------------------------------------------------------------
   localparam logic [4:0] IDX_CTL = 5'h00;
   localparam logic [4:0] IDX_CTL_B = 5'h01;
   localparam logic [4:0] IDX_CTL_C = 5'h02;
   localparam logic [4:0] IDX_FLAG0 = 5'h03;
   localparam logic [4:0] IDX_EN0 = 5'h08;
   localparam logic [4:0] IDX_PRIO0 = 5'h0D;
   localparam logic [4:0] IDX_RCTL = 5'h12;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL_GH = 7;
   localparam int CTL_GL = 6;
   localparam int CTL_T0_EN = 5;
   localparam int CTL_X0_EN = 4;
   localparam int CTL_PC_EN = 3;
   localparam int CTL_T0_FLAG = 2;
   localparam int CTL_X0_FLAG = 1;
   localparam int CTL_PC_FLAG = 0;
   localparam int CTB_T0_PRIO = 2;
   localparam int CTB_PC_PRIO = 0;
   localparam int CTC_X2_PRIO = 7;
   localparam int CTC_X1_PRIO = 6;
   localparam int CTC_X2_EN = 4;
   localparam int CTC_X1_EN = 3;
   localparam int CTC_X2_FLAG = 1;
   localparam int CTC_X1_FLAG = 0;
   localparam int RCTL_PSE = 7;

   // Source numbering: timer0, ext0, port change, ext1, ext2, periphs
   localparam int SRC_T0 = 0;
   localparam int SRC_X0 = 1;
   localparam int SRC_PC = 2;
   localparam int SRC_X1 = 3;
   localparam int SRC_X2 = 4;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] CTL_B_MASK = 8'hF5;
   localparam logic [7:0] CTL_B_RST = 8'hF5;
   localparam logic [7:0] CTL_C_MASK = 8'hD8;
   localparam logic [7:0] CTL_C_RST = 8'hC0;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [7:0] PRIO_RST = 8'hFF;
   localparam logic [7:0] RCTL_RST = 8'h00;

   // ----------------------------------------------------------------
   // Vectors and service state
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_HIGH = 16'h0008;
   localparam logic [15:0] VEC_LOW = 16'h0018;

   typedef enum logic [3:0] {
      SVC_IDLE = 4'b0001,
      SVC_LOW = 4'b0010,
      SVC_HIGH = 4'b0100,
      SVC_HIGH_OVER_LOW = 4'b1000
   } tlp_svc_t;

endpackage : tlp_pkg

// File: logic/tlp_source_cell.sv
// Purpose: One interrupt source: sticky flag and request gating.
// Assumes: Event and write strobes come from logic on the same clock.
// Notes: Requests are combinational from flag, enables and globals.

`timescale 1ns/1ps

module tlp_source_cell #(
   parameter bit PERIPH = 1'b0,
   parameter bit FIXED_HIGH = 1'b0
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic event_i,
   input wire logic wr_i,
   input wire logic wr_val_i,
   input wire logic en_i,
   input wire logic prio_i,
   input wire logic prio_mode_i,
   input wire logic gh_i,
   input wire logic gl_i,
   output logic flag_o,
   output logic hi_o,
   output logic lo_o
);
   logic flag;
   logic next_flag;
   logic eff_prio;
   logic pend;
   logic compat_ok;

   // Event beats a software clear in the same cycle
   assign next_flag = event_i | (wr_i ? wr_val_i : flag);
   assign eff_prio = FIXED_HIGH | prio_i;
   assign pend = flag & en_i;
   assign compat_ok = gh_i & (~PERIPH | gl_i);
   // Compatibility mode ignores priority and always uses high vector
   assign hi_o = prio_mode_i ? (pend & eff_prio & gh_i)
      : (pend & compat_ok);
   assign lo_o = prio_mode_i & pend & ~eff_prio & gh_i & gl_i;
   assign flag_o = flag;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

endmodule : tlp_source_cell

// File: logic/tlp_unit.sv
// Purpose: Two-level prioritised interrupt unit with APB registers.
// Assumes: Core acknowledge and return strobes are one-cycle pulses on
//          the same clock; event inputs are same-clock pulses.
// Notes: IRQ_O and VECTOR_O are registered, one cycle behind the cause.

`timescale 1ns/1ps

module tlp_unit (
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [tlp_pkg::NUM_CORE-1:0] CORE_EVENT_I,
   input wire logic [tlp_pkg::NUM_PERIPH-1:0] PERIPH_EVENT_I,
   input wire logic ACK_I,
   input wire logic RETURN_I,
   output logic IRQ_O,
   output logic [15:0] VECTOR_O
);
   import tlp_pkg::*;

   // ----------------------------------------------------------------
   // Registers and wires
   // ----------------------------------------------------------------
   logic [7:3] ctl, next_ctl;
   logic [7:0] ctl_b, ctl_c, rctl;
   logic [7:0] en_reg [NUM_PREG];
   logic [7:0] prio_reg [NUM_PREG];
   logic [31:0] prdata;
   logic [15:0] vector;
   tlp_svc_t svc, next_svc;

   logic [NUM_SRC-1:0] src_flag, src_en, src_prio, src_wr;
   logic [NUM_SRC-1:0] src_wval, src_evt, src_hi, src_lo;

   logic [4:0] idx;
   logic [7:0] rd_byte;
   logic irq, addr_ok, wr_go, rd_setup;
   logic prio_mode, gh, gl, any_hi, any_lo;
   logic accept, accept_hi, accept_lo, ret_gh, ret_gl;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign idx = PADDR_I[6:2];
   assign addr_ok = (PADDR_I[1:0] == 2'b00) && !PADDR_I[7]
      && (idx < 5'(REG_COUNT));
   assign wr_go = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
   assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
   assign PRDATA_O = prdata;

   always_comb begin
      rd_byte = 8'h00;
      if (idx == IDX_CTL) begin
         rd_byte = {ctl, src_flag[SRC_T0], src_flag[SRC_X0],
            src_flag[SRC_PC]};
      end else if (idx == IDX_CTL_B) begin
         rd_byte = ctl_b;
      end else if (idx == IDX_CTL_C) begin
         rd_byte = ctl_c | {6'h00, src_flag[SRC_X2], src_flag[SRC_X1]};
      end else if (idx >= IDX_FLAG0 && idx < IDX_EN0) begin
         rd_byte = src_flag[NUM_CORE + 8 * (32'(idx - IDX_FLAG0)) +: 8];
      end else if (idx >= IDX_EN0 && idx < IDX_PRIO0) begin
         rd_byte = en_reg[3'(idx - IDX_EN0)];
      end else if (idx >= IDX_PRIO0 && idx < IDX_RCTL) begin
         rd_byte = prio_reg[3'(idx - IDX_PRIO0)];
      end else if (idx == IDX_RCTL) begin
         rd_byte = rctl;
      end
   end

   // Read data is latched in the setup phase so access needs no wait
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= addr_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   assign prio_mode = rctl[RCTL_PSE];
   assign gh = ctl[CTL_GH];
   assign gl = ctl[CTL_GL];

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctl_b <= CTL_B_RST;
         ctl_c <= CTL_C_RST;
         rctl <= RCTL_RST;
      end else if (wr_go) begin
         if (idx == IDX_CTL_B) begin
            ctl_b <= PWDATA_I[7:0] & CTL_B_MASK;
         end else if (idx == IDX_CTL_C) begin
            ctl_c <= PWDATA_I[7:0] & CTL_C_MASK;
         end else if (idx == IDX_RCTL) begin
            rctl <= PWDATA_I[7:0] & 8'h80;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_PREG; g++) begin : g_preg
         always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
            if (!RSTN_I) begin
               en_reg[g] <= EN_RST;
               prio_reg[g] <= PRIO_RST;
            end else if (wr_go && idx == IDX_EN0 + 5'(g)) begin
               en_reg[g] <= PWDATA_I[7:0];
            end else if (wr_go && idx == IDX_PRIO0 + 5'(g)) begin
               prio_reg[g] <= PWDATA_I[7:0];
            end
         end
      end
   endgenerate

   // Hardware accept and return override a software write to globals
   always_comb begin
      next_ctl = ctl;
      if (wr_go && idx == IDX_CTL) begin
         next_ctl = PWDATA_I[7:3];
      end
      if (accept_hi) begin
         next_ctl[CTL_GH] = 1'b0;
      end else if (accept_lo) begin
         next_ctl[CTL_GL] = 1'b0;
      end else if (ret_gh) begin
         next_ctl[CTL_GH] = 1'b1;
      end else if (ret_gl) begin
         next_ctl[CTL_GL] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctl <= CTL_RST[7:3];
      end else begin
         ctl <= next_ctl;
      end
   end

   // ----------------------------------------------------------------
   // Source cells
   // ----------------------------------------------------------------
   assign src_en[NUM_CORE-1:0] = {ctl_c[CTC_X2_EN], ctl_c[CTC_X1_EN],
      ctl[CTL_PC_EN], ctl[CTL_X0_EN], ctl[CTL_T0_EN]};
   assign src_prio[NUM_CORE-1:0] = {ctl_c[CTC_X2_PRIO],
      ctl_c[CTC_X1_PRIO], ctl_b[CTB_PC_PRIO], 1'b1,
      ctl_b[CTB_T0_PRIO]};
   assign src_wval[NUM_CORE-1:0] = {PWDATA_I[CTC_X2_FLAG],
      PWDATA_I[CTC_X1_FLAG], PWDATA_I[CTL_PC_FLAG],
      PWDATA_I[CTL_X0_FLAG], PWDATA_I[CTL_T0_FLAG]};
   assign src_wr[NUM_CORE-1:0] = {{2{wr_go && idx == IDX_CTL_C}},
      {3{wr_go && idx == IDX_CTL}}};
   assign src_evt = {PERIPH_EVENT_I, CORE_EVENT_I};

   generate
      for (g = 0; g < NUM_PERIPH; g++) begin : g_pmap
         assign src_en[NUM_CORE + g] = en_reg[g / 8][g % 8];
         assign src_prio[NUM_CORE + g] = prio_reg[g / 8][g % 8];
         assign src_wval[NUM_CORE + g] = PWDATA_I[g % 8];
         assign src_wr[NUM_CORE + g] = wr_go
            && (idx == IDX_FLAG0 + 5'(g / 8));
      end
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         localparam bit IS_PERIPH = (g >= NUM_CORE);
         localparam bit IS_FIXED = (g == SRC_X0);
         tlp_source_cell #(
            .PERIPH(IS_PERIPH),
            .FIXED_HIGH(IS_FIXED)
         ) u_cell (
            .clk_i(REF_CLK_I),
            .rstn_i(RSTN_I),
            .event_i(src_evt[g]),
            .wr_i(src_wr[g]),
            .wr_val_i(src_wval[g]),
            .en_i(src_en[g]),
            .prio_i(src_prio[g]),
            .prio_mode_i(prio_mode),
            .gh_i(gh),
            .gl_i(gl),
            .flag_o(src_flag[g]),
            .hi_o(src_hi[g]),
            .lo_o(src_lo[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Request, vector and service tracking
   // ----------------------------------------------------------------
   assign any_hi = |src_hi;
   assign any_lo = |src_lo;
   assign accept = IRQ_O && ACK_I;
   assign accept_hi = accept && (vector == VEC_HIGH);
   assign accept_lo = accept && (vector == VEC_LOW);
   // Return restores the level that was entered last
   assign ret_gh = RETURN_I && (!prio_mode || svc == SVC_HIGH
      || svc == SVC_HIGH_OVER_LOW || svc == SVC_IDLE);
   assign ret_gl = RETURN_I && prio_mode && svc == SVC_LOW;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         irq <= 1'b0;
         vector <= VEC_HIGH;
      end else begin
         // Drop at once on accept so one request is never taken twice
         irq <= (any_hi || any_lo) && !accept;
         vector <= any_hi ? VEC_HIGH : VEC_LOW;
      end
   end
   assign IRQ_O = irq;
   assign VECTOR_O = vector;

   always_comb begin
      next_svc = svc;
      case (svc)
         SVC_IDLE: begin
            if (accept_hi) begin
               next_svc = SVC_HIGH;
            end else if (accept_lo) begin
               next_svc = SVC_LOW;
            end
         end
         SVC_LOW: begin
            if (accept_hi) begin
               next_svc = SVC_HIGH_OVER_LOW;
            end else if (RETURN_I) begin
               next_svc = SVC_IDLE;
            end
         end
         SVC_HIGH: begin
            if (RETURN_I) begin
               next_svc = SVC_IDLE;
            end
         end
         SVC_HIGH_OVER_LOW: begin
            if (RETURN_I) begin
               next_svc = SVC_LOW;
            end
         end
         default: begin
            next_svc = SVC_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         svc <= SVC_IDLE;
      end else begin
         svc <= next_svc;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);

   sequence s_accept_hi;
      IRQ_O && ACK_I && VECTOR_O == VEC_HIGH;
   endsequence
   sequence s_accept_lo;
      IRQ_O && ACK_I && VECTOR_O == VEC_LOW;
   endsequence

   property p_compat_vec;
      !prio_mode && $stable(prio_mode) && IRQ_O |-> VECTOR_O == VEC_HIGH;
   endproperty
   a_compat_vec: assert property (p_compat_vec)
      else $error("compatibility request not at high vector");

   property p_ext0_high;
      prio_mode && src_flag[SRC_X0] && src_en[SRC_X0] && gh && !ACK_I
         |=> IRQ_O && VECTOR_O == VEC_HIGH;
   endproperty
   a_ext0_high: assert property (p_ext0_high)
      else $error("external request zero not raised as high");

   property p_low_req;
      prio_mode && any_lo && !any_hi && !accept
         |=> IRQ_O && VECTOR_O == VEC_LOW;
   endproperty
   a_low_req: assert property (p_low_req)
      else $error("low request not presented at low vector");

   property p_high_first;
      any_hi && any_lo && !accept |=> IRQ_O && VECTOR_O == VEC_HIGH;
   endproperty
   a_high_first: assert property (p_high_first)
      else $error("high request not presented first");

   property p_accept_hi;
      s_accept_hi |=> !gh && !IRQ_O;
   endproperty
   a_accept_hi: assert property (p_accept_hi)
      else $error("high accept did not clear high enable");

   property p_accept_lo;
      prio_mode && !RETURN_I ##0 s_accept_lo |=> !gl && svc == SVC_LOW;
   endproperty
   a_accept_lo: assert property (p_accept_lo)
      else $error("low accept did not clear low enable");

   property p_gh_blocks;
      !gh |=> !IRQ_O;
   endproperty
   a_gh_blocks: assert property (p_gh_blocks)
      else $error("request raised while high enable clear");

   property p_flag_set;
      CORE_EVENT_I[SRC_T0] |=> src_flag[SRC_T0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("event did not set its flag");

   property p_ret_high;
      RETURN_I && !ACK_I && svc == SVC_HIGH_OVER_LOW
         |=> gh && svc == SVC_LOW;
   endproperty
   a_ret_high: assert property (p_ret_high)
      else $error("return from nested high service mishandled");

   property p_preempt;
      svc == SVC_LOW ##0 s_accept_hi |=> svc == SVC_HIGH_OVER_LOW;
   endproperty
   a_preempt: assert property (p_preempt)
      else $error("high request did not preempt low service");

endmodule : tlp_unit

// File: sim/tlp_core_model.sv
// Purpose: Behavioural processor core on the vector side of the unit.
// Assumes: One clock; acknowledge and return are one-cycle pulses.
// Notes: Acknowledge delay of 0 to 3 cycles is set by the bench.

`timescale 1ns/1ps

module tlp_core_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic irq_i,
   input wire logic [1:0] dly_i,
   input wire logic ret_req_i,
   output logic ack_o,
   output logic ret_o,
   output logic [3:0] depth_o
);
   logic [1:0] wait_cnt;

   // ----------------------------------------------------------------
   // Accept and return
   // ----------------------------------------------------------------
   // A cycle always separates an acknowledge from a return
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         wait_cnt <= 2'h0;
         depth_o <= 4'h0;
      end else begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         if (ret_req_i && !ack_o && !ret_o) begin
            ret_o <= 1'b1;
            depth_o <= depth_o - 4'h1;
         end else if (irq_i && !ack_o && !ret_o) begin
            if (wait_cnt >= dly_i) begin
               ack_o <= 1'b1;
               depth_o <= depth_o + 4'h1;
               wait_cnt <= 2'h0;
            end else begin
               wait_cnt <= wait_cnt + 2'h1;
            end
         end
      end
   end
endmodule : tlp_core_model

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the two-level interrupt unit.
// Assumes: APB slave with no wait states; core model acks requests.
// Notes: Any vector taken while none is expected counts as an error.

`timescale 1ns/1ps

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
   bad_count++; $display("Error %s expected %0h seen %0h", n, e, g); \
   end end

module tb_top;
   import tlp_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ack, ret, irq, ret_req = 1'b0;
   logic [4:0] cev = 5'h00;
   logic [NUM_PERIPH-1:0] pev = '0;
   logic [15:0] vec, xv;
   logic [3:0] depth;
   logic [1:0] dly = 2'h0;
   logic [32:0] exp_rd[$];
   logic [15:0] exp_vec[$];
   logic [32:0] e;
   int bad_count = 0, checks = 0, cyc = 0, r, b, i, n;
   logic [7:0] d;

   always #2 clk = ~clk;

   tlp_unit DUT (.REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CORE_EVENT_I(cev), .PERIPH_EVENT_I(pev),
      .ACK_I(ack), .RETURN_I(ret), .IRQ_O(irq), .VECTOR_O(vec));

   tlp_core_model u_core (.clk_i(clk), .rstn_i(rstn), .irq_i(irq),
      .dly_i(dly), .ret_req_i(ret_req), .ack_o(ack), .ret_o(ret),
      .depth_o(depth));

   function automatic logic [7:0] ad(input logic [4:0] x);
      return {1'b0, x, 2'b00};
   endfunction : ad

   task tally_and_finish;
      $display("Checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, a, {24'h0, v});
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] v, input logic er);
      exp_rd.push_back({er, 24'h0, v});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task ev(input logic [4:0] c, input logic [NUM_PERIPH-1:0] p);
      @(posedge clk);
      cev <= c;
      pev <= p;
      @(posedge clk);
      cev <= '0;
      pev <= '0;
   endtask : ev

   task ret_core;
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask : ret_core

   task wait_vec;
      n = 0;
      while (exp_vec.size() != 0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK("vector taken", 1'b1, n < 100)
   endtask : wait_vec

   // ----------------------------------------------------------------
   // Watcher and timeout
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (psel && penable && !pwrite && pready === 1'b1) begin
         e = exp_rd.size() ? exp_rd.pop_front() : 33'h1FFFFFFFF;
         `CHK("prdata", e[31:0], prdata)
         `CHK("pslverr", e[32], pslverr)
      end
      if (ack && irq === 1'b1) begin
         `CHK("vector expected", 1'b1, exp_vec.size() != 0)
         if (exp_vec.size()) begin
            xv = exp_vec.pop_front();
            `CHK("vector", xv, vec)
         end
      end
      if (cyc > 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h05E596E9));
      r = $urandom % 5;
      b = $urandom % 8;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      dly <= 2'($urandom);
      for (i = 0; i < REG_COUNT; i++)
         rd(ad(5'(i)), i == 1 ? 8'hF5 : i == 2 ? 8'hC0 :
            (i >= 13 && i < 18) ? 8'hFF : 8'h00, 1'b0);
      rd(8'h4C, 8'h00, 1'b1);
      rd(8'h05, 8'h00, 1'b1);
      wr(ad(IDX_RCTL), 8'hFF);
      rd(ad(IDX_RCTL), 8'h80, 1'b0);
      wr(ad(IDX_RCTL), 8'h00);
      for (i = 0; i < NUM_PREG; i++) begin
         d = 8'($urandom);
         wr(ad(IDX_EN0 + 5'(i)), d);
         rd(ad(IDX_EN0 + 5'(i)), d, 1'b0);
         wr(ad(IDX_EN0 + 5'(i)), 8'h00);
         wr(ad(IDX_PRIO0 + 5'(i)), ~d);
         rd(ad(IDX_PRIO0 + 5'(i)), ~d, 1'b0);
      end
      ev(5'h01, '0);
      rd(ad(IDX_CTL), 8'h04, 1'b0);
      wr(ad(IDX_CTL), 8'h00);
      // Compatibility mode, low priority bit must be ignored
      wr(ad(IDX_PRIO0 + 5'(r)), 8'h00);
      wr(ad(IDX_EN0 + 5'(r)), 8'(1 << b));
      wr(ad(IDX_CTL), 8'h80);
      ev(5'h00, NUM_PERIPH'(1) << (8 * r + b));
      repeat (8) @(posedge clk);
      exp_vec.push_back(VEC_HIGH);
      wr(ad(IDX_CTL), 8'hC0);
      wait_vec();
      rd(ad(IDX_CTL), 8'h40, 1'b0);
      wr(ad(IDX_FLAG0 + 5'(r)), 8'h00);
      ret_core();
      rd(ad(IDX_CTL), 8'hC0, 1'b0);
      wr(ad(IDX_CTL), 8'h60);
      ev(5'h01, '0);
      repeat (8) @(posedge clk);
      exp_vec.push_back(VEC_HIGH);
      wr(ad(IDX_CTL), 8'hA4);
      wait_vec();
      wr(ad(IDX_CTL), 8'h00);
      ret_core();
      // Priority mode: ext zero high, chosen peripheral low
      dly <= 2'($urandom);
      wr(ad(IDX_PRIO0 + 5'(r)), ~8'(1 << b));
      wr(ad(IDX_RCTL), 8'h80);
      wr(ad(IDX_CTL), 8'h50);
      ev(5'h02, NUM_PERIPH'(1) << (8 * r + b));
      repeat (8) @(posedge clk);
      exp_vec.push_back(VEC_HIGH);
      exp_vec.push_back(VEC_LOW);
      wr(ad(IDX_CTL), 8'hD2);
      n = 0;
      while (exp_vec.size() == 2 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK("high first", 1'b1, n < 100)
      rd(ad(IDX_CTL), 8'h52, 1'b0);
      wr(ad(IDX_CTL), 8'h50);
      ret_core();
      wait_vec();
      exp_vec.push_back(VEC_HIGH);
      ev(5'h02, '0);
      wait_vec();
      wr(ad(IDX_CTL), 8'h10);
      ret_core();
      rd(ad(IDX_CTL), 8'h90, 1'b0);
      repeat (8) @(posedge clk);
      exp_vec.push_back(VEC_LOW);
      ret_core();
      wait_vec();
      wr(ad(IDX_FLAG0 + 5'(r)), 8'h00);
      wr(ad(IDX_EN0 + 5'(r)), 8'h00);
      ev(5'h00, NUM_PERIPH'(1) << (8 * r + b));
      ret_core();
      repeat (8) @(posedge clk);
      rd(ad(IDX_FLAG0 + 5'(r)), 8'(1 << b), 1'b0);
      repeat (4) @(posedge clk);
      `CHK("reads left", 0, exp_rd.size())
      `CHK("core depth", 4'h0, depth)
      tally_and_finish();
   end
endmodule : tb_top
